// ===== design/shm_pkg.sv
package shm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SLOT_US = 1000;
  localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
  localparam int BUSY_TIMEOUT_US = 16;
  localparam int BUSY_TIMEOUT_CYC = BUSY_TIMEOUT_US * CLK_MHZ;
  localparam int RATE_KBPS = 1000;
  localparam int MIN_RATE_KBPS = 200;
  // half serial period in clk cycles, rounded down
  localparam int HALF_BIT_CYC = (CLK_MHZ * 1000) / (2 * RATE_KBPS);
  localparam int MAX_HALF_BIT_CYC = (CLK_MHZ * 1000) / (2 * MIN_RATE_KBPS);
  localparam int TIMER_W = 8;

  // ---------------------------------------------------------------
  // command byte layout
  // ---------------------------------------------------------------
  localparam int CHAR_W = 8;
  localparam int CMD_KIND_MSB = 7;
  localparam int CMD_KIND_LSB = 6;
  localparam int CMD_COUNT_W = 6;
  localparam logic [5:0] MAX_CHARS = 6'h3F;
  localparam logic [5:0] DEF_CHARS = 6'h08;

  typedef enum logic [1:0] {
    CMD_STATUS = 2'h0,
    CMD_RECV = 2'h1,
    CMD_SEND = 2'h2,
    CMD_XFER = 2'h3
  } shm_cmd_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic selFirstN;
    logic selSecondN;
    logic sclk;
    logic mosi;
  } shm_pins_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } shm_byte_t;

  function automatic logic [7:0] shm_make_cmd(shm_cmd_t k, logic [5:0] n);
    shm_make_cmd = {k, n};
  endfunction

endpackage

// ===== design/shm_interval_timer.sv
`timescale 1ns/1ps
// 8-bit interval timer behind a prescaler; tick pulses once per period
module shm_interval_timer #(
  parameter int PRESCALE = 200,
  parameter logic [7:0] PERIOD = 8'h05
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic tick
);
  logic [15:0] preCnt_ff;
  logic [7:0] cnt_ff;
  logic preWrap;

  assign preWrap = (preCnt_ff == 16'(PRESCALE - 1));

  // ---------------------------------------------------------------
  // prescaler and count
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_ff <= 16'h0000;
      cnt_ff <= 8'h00;
      tick <= 1'b0;
    end else if (restart) begin
      preCnt_ff <= 16'h0000;
      cnt_ff <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      preCnt_ff <= preWrap ? 16'h0000 : preCnt_ff + 16'h0001;
      if (preWrap) begin
        if (cnt_ff == PERIOD - 8'h01) begin
          cnt_ff <= 8'h00;
          tick <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
  end
endmodule

// ===== design/shm_shifter.sv
`timescale 1ns/1ps
// one 8-bit character, msb first, type 1: data changes on the
// leading (falling) edge, sampled on the trailing (rising) edge
module shm_shifter
  import shm_pkg::*;
#(
  parameter int HALF_CYC = 100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] txData,
  input wire logic misoSync,
  output logic sclk,
  output logic mosi,
  output shm_pkg::shm_byte_t rxByte,
  output logic busy
);
  logic [15:0] halfCnt_ff;
  logic [3:0] edgeCnt_ff;
  logic [7:0] sh_ff;
  logic halfDone;

  assign halfDone = (halfCnt_ff == 16'(HALF_CYC - 1));

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt_ff <= 16'h0000;
      edgeCnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      sclk <= 1'b1;
      mosi <= 1'b1;
      busy <= 1'b0;
      rxByte <= '0;
    end else begin
      rxByte.valid <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          sh_ff <= txData;
          halfCnt_ff <= 16'h0000;
          edgeCnt_ff <= 4'h0;
        end
      end else if (halfDone) begin
        halfCnt_ff <= 16'h0000;
        edgeCnt_ff <= edgeCnt_ff + 4'h1;
        if (!edgeCnt_ff[0]) begin
          sclk <= 1'b0;                 // leading edge drives data
          mosi <= sh_ff[7];
        end else begin
          sclk <= 1'b1;                 // trailing edge samples
          sh_ff <= {sh_ff[6:0], misoSync};
          if (edgeCnt_ff == 4'hF) begin
            busy <= 1'b0;
            rxByte.valid <= 1'b1;
            rxByte.data <= {sh_ff[6:0], misoSync};
          end
        end
      end else begin
        halfCnt_ff <= halfCnt_ff + 16'h0001;
      end
    end
  end
endmodule

// ===== design/shm_master.sv
`timescale 1ns/1ps
module shm_master
  import shm_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT_CYC,
  // one slot count is 4 us, so 250 counts make the 1 ms slot
  parameter int TIMER_PRESCALE = 4 * CLK_MHZ,
  parameter logic [7:0] SLOT_PERIOD = 8'hFA,
  parameter logic [7:0] TIMEOUT_PERIOD = 8'h10,
  parameter logic [5:0] DATA_CHARS = DEF_CHARS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire shm_pkg::shm_cmd_t dataCmd,
  input wire logic useBusy,
  input wire logic useTimeout,
  input wire logic [7:0] txChar,
  output logic txTake,
  output shm_pkg::shm_byte_t rxChar,
  output logic [7:0] slaveStatus,
  output logic slaveAbsent,
  output logic activeSlave,
  input wire logic busyPin,
  input wire logic serialDataIn,
  output logic slave_select_first_n,
  output logic slave_select_second_n,
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic transfer_done_irq
);
  import shm_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT = 6'h02,
    ST_CMD = 6'h04,
    ST_DATA = 6'h08,
    ST_END = 6'h10,
    ST_SEL = 6'h20
  } shm_state_t;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] busySync_ff;
  logic [1:0] misoSync_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busySync_ff <= 2'b11;
      misoSync_ff <= 2'b00;
    end else begin
      busySync_ff <= {busySync_ff[0], busyPin};
      misoSync_ff <= {misoSync_ff[0], serialDataIn};
    end
  end

  logic busyLow;
  assign busyLow = !busySync_ff[1] || !useBusy;

  shm_state_t state_ff;
  logic phaseCmd_ff;           // 1: status slot, 0: data slot
  logic cmdSent_ff;
  logic [5:0] remain_ff;
  logic sel_ff;
  logic shStart;
  logic [7:0] shData;
  logic shBusy;
  logic slotTick;
  logic toTick;
  logic toRestart;
  shm_byte_t shRx;

  // ---------------------------------------------------------------
  // the two interval timers
  // ---------------------------------------------------------------
  // slot timer free runs so slots stay on a fixed 1 ms grid
  shm_interval_timer #(
    .PRESCALE(TIMER_PRESCALE),
    .PERIOD(SLOT_PERIOD)
  ) u_slot (
    .clk(clk),
    .rst_n(rst_n),
    .restart(1'b0),
    .tick(slotTick)
  );

  assign toRestart = (state_ff != ST_WAIT);

  // timeout timer held cleared outside a wait, so it runs only from
  // select fall or the end of a character other than the slot's last until busy reads low; its counts
  // run four times faster than slot counts, 16 of them give 16 us
  shm_interval_timer #(
    .PRESCALE(TIMER_PRESCALE / 4),
    .PERIOD(TIMEOUT_PERIOD)
  ) u_timeout (
    .clk(clk),
    .rst_n(rst_n),
    .restart(toRestart),
    .tick(toTick)
  );

  // ---------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------
  shm_shifter #(
    .HALF_CYC(HALF_CYC)
  ) u_shift (
    .clk(clk),
    .rst_n(rst_n),
    .start(shStart),
    .txData(shData),
    .misoSync(misoSync_ff[1]),
    .sclk(serial_clock_out),
    .mosi(serial_data_out),
    .rxByte(shRx),
    .busy(shBusy)
  );

  // command kind chosen for this slot
  shm_cmd_t slotKind;
  logic [5:0] slotCount;
  always_comb begin
    slotKind = phaseCmd_ff ? CMD_STATUS : dataCmd;
    slotCount = phaseCmd_ff ? 6'h00 : remain_ff;
  end

  logic wantByte;
  assign wantByte = (state_ff == ST_WAIT) && busyLow && !shBusy;

  // ---------------------------------------------------------------
  // start of each character
  // ---------------------------------------------------------------
  always_comb begin
    shStart = wantByte;
    if (!cmdSent_ff) begin
      shData = shm_make_cmd(slotKind, slotCount);
    end else if (slotKind == CMD_RECV || slotKind == CMD_STATUS) begin
      shData = 8'hFF;          // idle fill when nothing is sent
    end else begin
      shData = txChar;
    end
  end
  assign txTake = wantByte && cmdSent_ff && !phaseCmd_ff &&
                  (slotKind == CMD_SEND || slotKind == CMD_XFER);

  // ---------------------------------------------------------------
  // slot sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      phaseCmd_ff <= 1'b1;
      cmdSent_ff <= 1'b0;
      remain_ff <= 6'h00;
      sel_ff <= 1'b0;
      slaveAbsent <= 1'b0;
      slaveStatus <= 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (slotTick) begin
            state_ff <= ST_WAIT;      // select falls here
            cmdSent_ff <= 1'b0;
            remain_ff <= phaseCmd_ff ? 6'h01 :
                         ((DATA_CHARS > MAX_CHARS) ? MAX_CHARS
                                                   : DATA_CHARS);
          end
        end
        ST_WAIT: begin
          if (wantByte) begin
            state_ff <= cmdSent_ff ? ST_DATA : ST_CMD;
          end else if (toTick && useTimeout) begin
            slaveAbsent <= 1'b1;
            phaseCmd_ff <= 1'b1;
            state_ff <= ST_END;
          end
        end
        ST_CMD: begin
          if (shRx.valid) begin
            cmdSent_ff <= 1'b1;
            state_ff <= ST_WAIT;       // re-time busy
          end
        end
        ST_DATA: begin
          if (shRx.valid) begin
            if (phaseCmd_ff) begin
              slaveStatus <= shRx.data;
              slaveAbsent <= 1'b0;
              phaseCmd_ff <= 1'b0;
              state_ff <= ST_END;
            end else if (remain_ff <= 6'h01) begin
              phaseCmd_ff <= 1'b1;
              state_ff <= ST_SEL;      // full sequence done
            end else begin
              remain_ff <= remain_ff - 6'h01;
              state_ff <= ST_WAIT;
            end
          end
        end
        ST_END: begin
          // status slot leaves phase at data unless aborted
          state_ff <= phaseCmd_ff ? ST_SEL : ST_IDLE;
        end
        ST_SEL: begin
          sel_ff <= !sel_ff;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // select outputs and completion strobes
  // ---------------------------------------------------------------
  logic selActive;
  assign selActive = (state_ff == ST_WAIT) || (state_ff == ST_CMD) ||
                     (state_ff == ST_DATA);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_select_first_n <= 1'b1;
      slave_select_second_n <= 1'b1;
      transfer_done_irq <= 1'b0;
      rxChar <= '0;
    end else begin
      slave_select_first_n <= !(selActive && !sel_ff);
      slave_select_second_n <= !(selActive && sel_ff);
      transfer_done_irq <= shRx.valid;
      rxChar.valid <= shRx.valid && state_ff == ST_DATA && !phaseCmd_ff &&
                      (slotKind == CMD_RECV || slotKind == CMD_XFER);
      rxChar.data <= shRx.data;
    end
  end

  assign activeSlave = sel_ff;
endmodule

// ===== tb/shm_master_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// protocol checker on the master's pins
// ---------------------------------------------------------------
module shm_master_assertions #(
  parameter int HALF_CYC = 5,
  parameter int TMO_CYC = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic useBusy,
  input wire logic useTimeout,
  input wire logic busyPin,
  input wire logic slaveAbsent,
  input wire logic activeSlave,
  input wire logic slave_select_first_n,
  input wire logic slave_select_second_n,
  input wire logic serial_clock_out,
  input wire logic transfer_done_irq
);
  logic anySel;
  logic [7:0] lowCnt_ff;
  logic [7:0] riseCnt_ff;
  logic [7:0] waitCnt_ff;
  assign anySel = !slave_select_first_n || !slave_select_second_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // low time of the serial clock, cleared while it is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lowCnt_ff <= 8'h00;
    else if (serial_clock_out) lowCnt_ff <= 8'h00;
    else lowCnt_ff <= lowCnt_ff + 8'h01;
  end
  // rising edges within one character
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) riseCnt_ff <= 8'h00;
    else if (transfer_done_irq) riseCnt_ff <= 8'h00;
    else if (serial_clock_out && lowCnt_ff != 8'h00)
      riseCnt_ff <= riseCnt_ff + 8'h01;
  end
  // cycles spent waiting for a ready slave between characters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) waitCnt_ff <= 8'h00;
    else if (anySel && useBusy && useTimeout && busyPin &&
             serial_clock_out && riseCnt_ff == 8'h00)
      waitCnt_ff <= waitCnt_ff + 8'h01;
    else waitCnt_ff <= 8'h00;
  end
  // sync latency is up to three cycles, so five high samples are safe
  sequence busyHeld_s;
    (useBusy && busyPin)[*5];
  endsequence
  sequence idleChar_s;
    riseCnt_ff == 8'h00;
  endsequence
  sel_exclusive_a: assert property (
    anySel |-> !(!slave_select_first_n && !slave_select_second_n))
    else $error("both selects low");
  sel_matches_a: assert property (
    anySel |-> activeSlave == !slave_select_second_n)
    else $error("select does not match active slave");
  clk_idle_a: assert property (!anySel |-> serial_clock_out)
    else $error("serial clock toggles without select");
  sel_before_clk_a: assert property (
    $fell(serial_clock_out) |-> $past(anySel))
    else $error("clocking began before select");
  half_period_a: assert property (
    $rose(serial_clock_out) |-> lowCnt_ff == HALF_CYC)
    else $error("serial clock low time wrong");
  char_bits_a: assert property (
    transfer_done_irq |-> riseCnt_ff == 8'h08)
    else $error("character not eight bits");
  busy_gate_a: assert property (
    busyHeld_s ##0 idleChar_s |-> !$fell(serial_clock_out))
    else $error("character started while slave busy");
  busy_timeout_a: assert property (
    waitCnt_ff <= TMO_CYC + 8)
    else $error("busy wait not abandoned in time");
  early_abort_a: assert property (
    $rose(slaveAbsent) |-> $past(waitCnt_ff) >= TMO_CYC - 4)
    else $error("slave dropped before timeout");
  switch_idle_a: assert property (
    $changed(activeSlave) |-> !anySel)
    else $error("slave switched while selected");
endmodule

// ===== tb/shm_slave_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// slave with busy handshake; answers 8'hA0 plus byte index
// ---------------------------------------------------------------
module shm_slave_model (
  input wire logic clk,
  input wire logic selN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [7:0] respDelay,
  output logic busy,
  output logic miso,
  output logic rxStrobe,
  output logic [7:0] rxData
);
  logic prevSclk;
  logic [7:0] cnt;
  logic [7:0] sh;
  logic [7:0] k;
  int bits;
  initial begin
    busy = 1'b1;
    miso = 1'b0;
    rxStrobe = 1'b0;
    rxData = 8'h00;
    prevSclk = 1'b1;
    cnt = 8'h00;
    sh = 8'h00;
    k = 8'hA0;
    bits = 0;
  end
  // respDelay 8'hFF never answers, which models an absent slave
  always @(posedge clk) begin
    rxStrobe <= 1'b0;
    prevSclk <= sclk;
    if (selN) begin
      busy <= 1'b1;
      cnt <= 8'h00;
      bits = 0;
      k <= 8'hA0;
      miso <= ~miso; // released line must not keep its last level
    end else begin
      if (!sclk && prevSclk) begin
        miso <= k[7 - bits];
        // not ready until byte handled; the delay restarts from here
        if (bits == 7) begin
          busy <= 1'b1;
          cnt <= 8'h00;
        end
      end
      if (sclk && !prevSclk) begin
        sh = {sh[6:0], mosi};
        bits++;
        if (bits == 8) begin
          rxStrobe <= 1'b1;
          rxData <= sh;
          bits = 0;
          k <= k + 8'h01;
          cnt <= 8'h00;
        end
      end else if (busy && respDelay != 8'hFF) begin
        cnt <= cnt + 8'h01;
        if (cnt >= respDelay) busy <= 1'b0;
      end
    end
  end
endmodule

// ===== tb/shm_master_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// bench: two slaves, all four kinds, slow, absent, always ready
// ---------------------------------------------------------------
module shm_master_tb;
  import shm_pkg::*;
  logic clk, rst_n, useBusy, useTimeout, busyPin, serialDataIn;
  logic txTake, slaveAbsent, activeSlave, transfer_done_irq;
  logic slave_select_first_n, slave_select_second_n;
  logic serial_clock_out, serial_data_out;
  logic bz1, bz2, so1, so2, st1, st2, chkRx, expSlave;
  logic [7:0] txChar, slaveStatus, dly1, dly2, rx1, rx2;
  shm_cmd_t dataCmd;
  shm_byte_t rxChar;
  logic [7:0] expMosi[$];
  logic [7:0] expMiso[$];
  int mismatches, tests_run, seed, n;
  time lastFall;
  shm_master #(.HALF_CYC(5), .TIMER_PRESCALE(16), .SLOT_PERIOD(8'h20),
    .DATA_CHARS(6'h03)) DUT (.*);
  shm_slave_model S1 (.clk(clk), .selN(slave_select_first_n),
    .sclk(serial_clock_out), .mosi(serial_data_out), .respDelay(dly1),
    .busy(bz1), .miso(so1), .rxStrobe(st1), .rxData(rx1));
  shm_slave_model S2 (.clk(clk), .selN(slave_select_second_n),
    .sclk(serial_clock_out), .mosi(serial_data_out), .respDelay(dly2),
    .busy(bz2), .miso(so2), .rxStrobe(st2), .rxData(rx2));
  // busy is pulled up when no slave is selected
  assign busyPin = !slave_select_first_n ? bz1 :
                   !slave_select_second_n ? bz2 : 1'b1;
  assign serialDataIn = !slave_select_second_n ? so2 : so1;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // bounded wait for the expected slave's select to reach lvl
  task automatic waitSel(input logic lvl);
    n = 0;
    while ((expSlave ? slave_select_second_n : slave_select_first_n)
           !== lvl) begin
      @(posedge clk);
      n++;
      if (n > 2000) begin
        check(16'h1, 16'h0);
        report_and_stop();
      end
    end
  endtask
  // one slot: note expected bytes, then judge the outcome
  task automatic slot(input logic st, input logic absent);
    logic [1:0] k;
    k = st ? 2'h0 : dataCmd;
    waitSel(1'b0);
    if (lastFall != 0) check(16'(($time - lastFall) / 5), 16'h0200);
    lastFall = $time;
    if (!absent) begin
      expMosi.push_back(st ? 8'h00 : {k, 6'h03});
      for (int i = 1; i <= (st ? 1 : 3); i++) begin
        if (st || k < 2'h2) expMosi.push_back(8'hFF);
        if (!st && k[0]) expMiso.push_back(8'(8'hA0 + i));
      end
    end
    chkRx = !st;
    waitSel(1'b1);
    chkRx = 1'b0;
    repeat (3) @(posedge clk);
    if (absent || !st) expSlave = !expSlave;
    check(16'(slaveAbsent), 16'(absent));
    if (st && !absent) check(16'(slaveStatus), 16'h00A1);
    check(16'(activeSlave), 16'(expSlave));
    check(16'(expMosi.size() + expMiso.size()), 16'h0);
  endtask
  // watcher: compare every finished character with the oldest note
  always @(posedge clk) begin
    if (st1 || st2) begin
      if (expMosi.size() == 0) check(16'h1, 16'h0);
      else check(16'(st1 ? rx1 : rx2), 16'(expMosi.pop_front()));
    end
    if (rxChar.valid && chkRx && dataCmd[0]) begin
      if (expMiso.size() == 0) check(16'h1, 16'h0);
      else check(16'(rxChar.data), 16'(expMiso.pop_front()));
    end
    if (txTake) expMosi.push_back(txChar);
  end
  // fresh random character after each one taken
  always @(posedge clk) begin
    if (txTake) txChar <= #1 8'($random(seed));
  end
  initial begin
    seed = 7;
    rst_n = 1'b0;
    dataCmd = CMD_STATUS;
    useBusy = 1'b1;
    useTimeout = 1'b1;
    txChar = 8'h5A;
    dly1 = 8'h03;
    dly2 = 8'h08;
    chkRx = 1'b0;
    expSlave = 1'b0;
    mismatches = 0;
    tests_run = 0;
    lastFall = 0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int c = 0; c < 4; c++) begin
      #1 dataCmd = shm_cmd_t'(c);
      dly1 = 8'($random(seed) & 7);
      slot(1'b1, 1'b0);
      slot(1'b0, 1'b0);
    end
    #1 dly2 = 8'hFF;
    slot(1'b1, 1'b0);
    slot(1'b0, 1'b0);
    slot(1'b1, 1'b1); // silent second slave is dropped
    slot(1'b1, 1'b0);
    #1 useBusy = 1'b0; // always-ready wiring ignores the busy line
    slot(1'b0, 1'b0);
    slot(1'b1, 1'b0);
    report_and_stop();
  end
endmodule
bind shm_master shm_master_assertions #(.HALF_CYC(HALF_CYC),
  .TMO_CYC((TIMER_PRESCALE / 4) * TIMEOUT_PERIOD)) CHK (.*);
